// File: src/fpd_pkg.sv
/*
  Shared constants and types of the 14-bit pulse-width DAC: register map,
  field positions, reset values, prescaler divisions and bus state encodings.
  Assumes a single 200 MHz system clock and a 32-bit AXI4-Lite register port.
*/
package fpd_pkg;
  // Register byte offsets
  localparam int unsigned AXI_AW        = 4;
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_PRESC     = 4'h4;
  localparam logic [3:0]  OFF_VALUE     = 4'h8;
  localparam logic [3:0]  OFF_STATUS    = 4'hc;
  // Field positions
  localparam int unsigned CTRL_CLS_BIT  = 0;
  localparam int unsigned CTRL_INV_BIT  = 1;
  localparam int unsigned PSEL_W        = 3;
  localparam int unsigned VALUE_W       = 14;
  localparam int unsigned STAT_LVL_BIT  = 0;
  localparam int unsigned STAT_IDX_LSB  = 8;
  localparam int unsigned STAT_STEP_LSB = 16;
  // Reset values
  localparam logic        RST_CLS       = 1'b0;
  localparam logic        RST_INV       = 1'b0;
  localparam logic [2:0]  RST_PSEL      = 3'h0;
  localparam logic [13:0] RST_VALUE     = 14'h0000;
  localparam logic        RST_PWM       = 1'b1;
  // Carrier geometry: last step of a base pulse, last base pulse of a conversion cycle
  localparam logic [7:0]  STEP_LAST_256 = 8'hff;
  localparam logic [7:0]  STEP_LAST_64  = 8'h3f;
  localparam logic [7:0]  IDX_LAST_256  = 8'h3f;
  localparam logic [7:0]  IDX_LAST_64   = 8'hff;
  localparam logic [13:0] CONST_LIM_256 = 14'h0040;
  localparam logic [13:0] CONST_LIM_64  = 14'h0100;
  // Prescaler divisions of the system clock per resolution step
  localparam int unsigned DIV_SEL0 = 32;
  localparam int unsigned DIV_SEL1 = 64;
  localparam int unsigned DIV_SEL2 = 128;
  localparam int unsigned DIV_SEL3 = 256;
  localparam int unsigned DIV_SEL4 = 1024;
  localparam int unsigned DIV_SEL5 = 4096;
  localparam int unsigned DIV_SEL6 = 16384;
  localparam logic [2:0]  PSEL_STOP = 3'h7;
  // Bus answers and channel states
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  typedef enum logic {FPD_WR_COLLECT = 1'b0, FPD_WR_RESP = 1'b1} fpd_wr_st_t;
  typedef enum logic {FPD_RD_IDLE = 1'b0, FPD_RD_DATA = 1'b1} fpd_rd_st_t;
endpackage

// File: src/fpd_bus_if.sv
/*
  Internal carrier between the register file, the prescaler and the PWM core.
  Assumes all three parties run on the same clock.
*/
`timescale 1ns/1ps
interface fpd_bus_if;
  logic        carrier_length_select;
  logic        output_polarity_invert;
  logic [2:0]  prescale_select;
  logic [13:0] pwm_value_register;
  logic        step_tick;
  logic [7:0]  base_index;
  logic [7:0]  step_count;
  logic        pwm_level;

  modport regs  (output carrier_length_select, output_polarity_invert, output prescale_select,
                 output pwm_value_register, input base_index, input step_count, input pwm_level);
  modport presc (input prescale_select, output step_tick);
  modport core  (input carrier_length_select, input output_polarity_invert, input pwm_value_register,
                 input step_tick, output base_index, output step_count, output pwm_level);
endinterface // fpd_bus_if

// File: src/fpd_prescaler.sv
/*
  Prescaler: one-cycle step enable every N system clocks, N picked by prescale_select.
  Assumes the selector is stable for long stretches; a change restarts the count cleanly.
*/
`timescale 1ns/1ps
module fpd_prescaler #(
  parameter int unsigned P_DIV_TOP = fpd_pkg::DIV_SEL6
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // Carrier to the core
  fpd_bus_if.presc  bus
);
  typedef struct packed {
    logic [14:0] cnt;
    logic [2:0]  sel;
    logic        tick;
  } fpd_presc_t;

  fpd_presc_t st, next_st;

  // Last count of one resolution step for a selector value
  function automatic logic [14:0] last_of(input logic [2:0] s);
    case (s)
      3'h0:    last_of = 15'(fpd_pkg::DIV_SEL0 - 1);
      3'h1:    last_of = 15'(fpd_pkg::DIV_SEL1 - 1);
      3'h2:    last_of = 15'(fpd_pkg::DIV_SEL2 - 1);
      3'h3:    last_of = 15'(fpd_pkg::DIV_SEL3 - 1);
      3'h4:    last_of = 15'(fpd_pkg::DIV_SEL4 - 1);
      3'h5:    last_of = 15'(fpd_pkg::DIV_SEL5 - 1);
      default: last_of = 15'(P_DIV_TOP - 1);
    endcase
  endfunction

  // Divider; the forbidden selector freezes the steps rather than guessing a rate
  always_comb begin
    next_st      = st;
    next_st.sel  = bus.prescale_select;
    next_st.tick = 1'b0;
    if (st.sel != bus.prescale_select || st.sel == fpd_pkg::PSEL_STOP) begin
      next_st.cnt = 15'h0000;
    end else if (st.cnt >= last_of(st.sel)) begin
      next_st.cnt  = 15'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 15'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st <= '{cnt: 15'h0000, sel: fpd_pkg::RST_PSEL, tick: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign bus.step_tick = st.tick;
endmodule // fpd_prescaler

// File: src/fpd_axil_regs.sv
/*
  AXI4-Lite slave holding control, prescaler and value registers plus a status view.
  Assumes at most one write and one read outstanding, as the bus master guarantees.
*/
`timescale 1ns/1ps
module fpd_axil_regs (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Write channels
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // Read channels
  input  wire logic [3:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Carrier
  fpd_bus_if.regs          bus
);
  typedef struct packed {
    fpd_pkg::fpd_wr_st_t wst;
    fpd_pkg::fpd_rd_st_t rst;
    logic        awready, wready, have_aw, have_w, bvalid, arready, rvalid;
    logic [3:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        cls, inv;
    logic [2:0]  psel;
    logic [13:0] value;
  } fpd_regs_t;

  fpd_regs_t st, next_st;

  // Merge a write word into an old word by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old_w[8*b +: 8] = strb[b] ? new_w[8*b +: 8] : old_w[8*b +: 8];
    end
    merge = old_w;
  endfunction

  // Read view of one register; unmapped words read as zero
  function automatic logic [31:0] view(input logic [3:0] a, input fpd_regs_t s);
    view = 32'h0000_0000;
    if (a == fpd_pkg::OFF_CTRL) begin
      view[fpd_pkg::CTRL_CLS_BIT] = s.cls;
      view[fpd_pkg::CTRL_INV_BIT] = s.inv;
    end else if (a == fpd_pkg::OFF_PRESC) begin
      view[fpd_pkg::PSEL_W-1:0] = s.psel;
    end else if (a == fpd_pkg::OFF_VALUE) begin
      view[fpd_pkg::VALUE_W-1:0] = s.value;
    end else if (a == fpd_pkg::OFF_STATUS) begin
      view[fpd_pkg::STAT_LVL_BIT]      = bus.pwm_level;
      view[fpd_pkg::STAT_IDX_LSB +: 8]  = bus.base_index;
      view[fpd_pkg::STAT_STEP_LSB +: 8] = bus.step_count;
    end
  endfunction

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == fpd_pkg::OFF_CTRL) || (a == fpd_pkg::OFF_PRESC) ||
             (a == fpd_pkg::OFF_VALUE) || (a == fpd_pkg::OFF_STATUS);
  endfunction

  // Channel handling: address and data may arrive in either order
  always_comb begin
    logic [31:0] w;
    w       = 32'h0000_0000;
    next_st = st;
    case (st.wst)
      fpd_pkg::FPD_WR_COLLECT: begin
        if (s_axi_awvalid_i && st.awready) begin
          next_st.have_aw = 1'b1;
          next_st.awready = 1'b0;
          next_st.waddr   = {s_axi_awaddr_i[3:2], 2'b00};
        end
        if (s_axi_wvalid_i && st.wready) begin
          next_st.have_w = 1'b1;
          next_st.wready = 1'b0;
          next_st.wdata  = s_axi_wdata_i;
          next_st.wstrb  = s_axi_wstrb_i;
        end
        if (next_st.have_aw && next_st.have_w) begin
          w = merge(view(next_st.waddr, st), next_st.wdata, next_st.wstrb);
          if (next_st.waddr == fpd_pkg::OFF_CTRL) begin
            next_st.cls = w[fpd_pkg::CTRL_CLS_BIT];
            next_st.inv = w[fpd_pkg::CTRL_INV_BIT];
          end else if (next_st.waddr == fpd_pkg::OFF_PRESC) begin
            next_st.psel = w[fpd_pkg::PSEL_W-1:0];
          end else if (next_st.waddr == fpd_pkg::OFF_VALUE) begin
            next_st.value = w[fpd_pkg::VALUE_W-1:0];
          end
          next_st.bresp  = mapped(next_st.waddr) ? fpd_pkg::RESP_OKAY : fpd_pkg::RESP_SLVERR;
          next_st.bvalid = 1'b1;
          next_st.wst    = fpd_pkg::FPD_WR_RESP;
        end
      end
      fpd_pkg::FPD_WR_RESP: begin
        if (s_axi_bready_i) begin
          next_st.bvalid  = 1'b0;
          next_st.have_aw = 1'b0;
          next_st.have_w  = 1'b0;
          next_st.awready = 1'b1;
          next_st.wready  = 1'b1;
          next_st.wst     = fpd_pkg::FPD_WR_COLLECT;
        end
      end
      default: next_st.wst = fpd_pkg::FPD_WR_COLLECT;
    endcase
    case (st.rst)
      fpd_pkg::FPD_RD_IDLE: begin
        if (s_axi_arvalid_i) begin
          next_st.rdata   = view({s_axi_araddr_i[3:2], 2'b00}, st);
          next_st.rresp   = mapped({s_axi_araddr_i[3:2], 2'b00}) ? fpd_pkg::RESP_OKAY : fpd_pkg::RESP_SLVERR;
          next_st.rvalid  = 1'b1;
          next_st.arready = 1'b0;
          next_st.rst     = fpd_pkg::FPD_RD_DATA;
        end
      end
      default: begin
        if (s_axi_rready_i) begin
          next_st.rvalid  = 1'b0;
          next_st.arready = 1'b1;
          next_st.rst     = fpd_pkg::FPD_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.cls     <= fpd_pkg::RST_CLS;
      st.inv     <= fpd_pkg::RST_INV;
      st.psel    <= fpd_pkg::RST_PSEL;
      st.value   <= fpd_pkg::RST_VALUE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs are flop fields
  assign s_axi_awready_o            = st.awready;
  assign s_axi_wready_o             = st.wready;
  assign s_axi_bvalid_o             = st.bvalid;
  assign s_axi_bresp_o              = st.bresp;
  assign s_axi_arready_o            = st.arready;
  assign s_axi_rvalid_o             = st.rvalid;
  assign s_axi_rdata_o              = st.rdata;
  assign s_axi_rresp_o              = st.rresp;
  assign bus.carrier_length_select  = st.cls;
  assign bus.output_polarity_invert = st.inv;
  assign bus.prescale_select        = st.psel;
  assign bus.pwm_value_register     = st.value;
endmodule // fpd_axil_regs

// File: src/fpd_top.sv
/*
  Top of the 14-bit pulse-width DAC: AXI4-Lite registers, step prescaler and the
  waveform core with base pulses and spread extra pulses.
  Assumes one 200 MHz clock, a synchronous active-low reset and an external
  low-pass filter on pwm_o.
*/
// Chosen here: the register offsets and register access over AXI4-Lite.
// Function
// (RULE1) Long carrier: each base pulse lasts 256 resolution steps.
// (RULE2) Long carrier: bits 13..6 give base duty, bits 5..0 place extra pulses.
// (RULE3) Short carrier: 64-step base, top six bits duty, low eight place extras.
// (RULE4) Invert set: value sets high time; clear: value sets low time.
// (RULE5) Selected base pulses grow by exactly one resolution step.
// (RULE6) Long carrier: values below 0x0040 give a constant level.
// (RULE7) Short carrier: values below 0x0100 give a constant level.
// (RULE8) Software zeroes two or four low bits for 12- or 10-bit accuracy.
// (RULE9) Base pulses repeat; the extra pattern recurs every conversion cycle.
`timescale 1ns/1ps
module fpd_top #(
  parameter int unsigned P_DIV_TOP = fpd_pkg::DIV_SEL6
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // AXI4-Lite write channels
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read channels
  input  wire logic [3:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Analog side, to the low-pass filter
  output logic             pwm_o
);
  typedef struct packed {
    logic [7:0]  step;
    logic [7:0]  idx;
    logic [13:0] value;
    logic        cls;
    logic        inv;
    logic        pwm;
  } fpd_core_t;

  fpd_bus_if bus ();
  fpd_core_t st, next_st;

  // Register file on the bus
  fpd_axil_regs u_regs (
    .clock_i         (clock_i),
    .nrst_i          (nrst_i),
    .s_axi_awaddr_i  (s_axi_awaddr_i),
    .s_axi_awvalid_i (s_axi_awvalid_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_wdata_i   (s_axi_wdata_i),
    .s_axi_wstrb_i   (s_axi_wstrb_i),
    .s_axi_wvalid_i  (s_axi_wvalid_i),
    .s_axi_wready_o  (s_axi_wready_o),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_araddr_i  (s_axi_araddr_i),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .bus             (bus.regs)
  );

  // Resolution step enable
  fpd_prescaler #(
    .P_DIV_TOP (P_DIV_TOP)
  ) u_presc (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .bus     (bus.presc)
  );

  // Bit reversal spreads extra pulses evenly instead of bunching them
  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = x[7-i];
    end
  endfunction

  logic        wrap;
  logic        conv_end;
  logic [7:0]  step_last;
  logic [7:0]  idx_last;
  logic [7:0]  duty;
  logic [7:0]  frac;
  logic [7:0]  slot_rank;
  logic        extra;
  logic [8:0]  width;
  logic        active;

  // Carrier geometry and field split of the latched value
  always_comb begin
    // (RULE1) long base period
    step_last = st.cls ? fpd_pkg::STEP_LAST_256 : fpd_pkg::STEP_LAST_64;
    // (RULE9) base pulses per conversion cycle
    idx_last  = st.cls ? fpd_pkg::IDX_LAST_256 : fpd_pkg::IDX_LAST_64;
    wrap      = bus.step_tick && (st.step == step_last);
    conv_end  = wrap && (st.idx == idx_last);
    // (RULE2) duty and placement fields
    duty      = st.cls ? st.value[13:6] : {2'b00, st.value[13:8]};
    frac      = st.cls ? {2'b00, st.value[5:0]} : st.value[7:0];
    slot_rank = st.cls ? rev8({~st.idx[5:0], 2'b00}) : rev8(~st.idx);
  end

  // Width of the active part of the current base pulse
  always_comb begin
    // (RULE5) one extra step in selected pulses
    extra  = (duty != 8'h00) && (slot_rank < frac);
    width  = {1'b0, duty} + {8'h00, extra};
    // (RULE6) (RULE7) zero duty keeps the line idle
    active = ({1'b0, st.step} < width);
  end

  // Next core state; value and mode are taken only at a base pulse edge so no runt pulses appear
  always_comb begin
    next_st = st;
    if (bus.step_tick) begin
      next_st.step = st.step + 8'h01;
    end
    // (RULE9) continuous repetition
    if (wrap) begin
      next_st.step  = 8'h00;
      next_st.idx   = (conv_end || st.cls != bus.carrier_length_select) ? 8'h00 : st.idx + 8'h01;
      next_st.value = bus.pwm_value_register;
      next_st.cls   = bus.carrier_length_select;
      next_st.inv   = bus.output_polarity_invert;
    end
    // (RULE4) polarity choice
    next_st.pwm = st.inv ? active : ~active;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st <= '{step: 8'h00, idx: 8'h00, value: fpd_pkg::RST_VALUE, cls: fpd_pkg::RST_CLS,
              inv: fpd_pkg::RST_INV, pwm: fpd_pkg::RST_PWM};
    end else begin
      st <= next_st;
    end
  end

  // Outputs and status view
  assign pwm_o          = st.pwm;
  assign bus.pwm_level  = st.pwm;
  assign bus.base_index = st.idx;
  assign bus.step_count = st.step;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // Named steps of a base pulse
  sequence s_long_wrap;
    st.cls && bus.step_tick && (st.step == fpd_pkg::STEP_LAST_256);
  endsequence

  sequence s_short_wrap;
    !st.cls && bus.step_tick && (st.step == fpd_pkg::STEP_LAST_64);
  endsequence

  sequence s_restart;
    (st.step == 8'h00);
  endsequence

  sequence s_conv_last;
    wrap && (st.idx == idx_last);
  endsequence

  chk_period_long: assert property (s_long_wrap |=> s_restart) // RULE1
    else $error("long carrier did not restart after step 255");

  chk_long_no_early: assert property (st.cls && bus.step_tick && st.step == 8'h3f |=> st.step == 8'h40) // RULE1
    else $error("long carrier ended after 64 steps");

  chk_period_short: assert property (s_short_wrap |=> s_restart) // RULE3
    else $error("short carrier did not restart after step 63");

  chk_short_range: assert property (!st.cls |-> st.step <= 8'h3f) // RULE3
    else $error("short carrier step beyond 63");

  chk_duty_long: assert property (st.cls && st.value[13:6] != 8'h00 && st.step < st.value[13:6] // RULE2
                                  |=> pwm_o == $past(st.inv))
    else $error("long carrier active part shorter than bits 13..6");

  chk_duty_short: assert property (!st.cls && st.value[13:8] != 6'h00 && st.step < {2'b00, st.value[13:8]} // RULE3
                                   |=> pwm_o == $past(st.inv))
    else $error("short carrier active part shorter than bits 13..8");

  chk_idle_tail: assert property ({1'b0, st.step} > {1'b0, duty} |=> pwm_o == !$past(st.inv)) // RULE4
    else $error("output active past duty plus extra step");

  chk_extra_step: assert property (duty != 8'h00 && st.step == duty // RULE5
                                   |=> pwm_o == ($past(extra) ? $past(st.inv) : !$past(st.inv)))
    else $error("extra step not matching placement field");

  chk_extra_slot: assert property (st.cls && st.value[5:0] == 6'h01 && duty != 8'h00 && extra // RULE5
                                   |-> st.idx == 8'h3f)
    else $error("lone extra pulse not in last base pulse");

  chk_const_long: assert property (st.cls && st.value < fpd_pkg::CONST_LIM_256 |=> pwm_o == !$past(st.inv)) // RULE6
    else $error("long carrier small value not constant");

  chk_const_short: assert property (!st.cls && st.value < fpd_pkg::CONST_LIM_64 |=> pwm_o == !$past(st.inv)) // RULE7
    else $error("short carrier small value not constant");

  chk_conv_wrap: assert property (s_conv_last |=> st.idx == 8'h00 ##0 s_restart) // RULE9
    else $error("conversion cycle did not restart");

  chk_step_hold: assert property (!bus.step_tick |=> $stable(st.step) && $stable(st.idx)) // RULE9
    else $error("step advanced without step enable");

  chk_value_hold: assert property (!wrap |=> $stable(st.value) && $stable(st.cls) && $stable(st.inv)) // RULE9
    else $error("latched value changed inside a base pulse");

  // (RULE9) inside a conversion cycle each base pulse takes the next index
  chk_idx_advance: assert property (wrap && !conv_end && (st.cls == bus.carrier_length_select) // RULE9
                                    |=> st.idx == $past(st.idx) + 8'h01)
    else $error("base pulse index did not advance by one");

  // Bus answers stand until the master takes them, however slow the master is
  chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before bready");

  chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before rready");
endmodule // fpd_top

// File: tb/fpd_lpf_model.sv
/*
  Stand-in for the low-pass filter on pwm_o: averages the pin over a window.
  Assumes the bench arms it for one clock with the window length in clocks.
*/
`timescale 1ns/1ps
module fpd_lpf_model (
  // Clock
  input  wire logic        clock_i,
  // Pin and window control
  input  wire logic        pwm_i,
  input  wire logic        arm_i,
  input  wire logic [31:0] win_i,
  // Accumulated high time
  output logic             done_o = 1'b0,
  output logic [31:0]      cnt_o = 32'h0
);
  logic [31:0] left = 32'h0;

  // Integrate high clocks; a whole number of periods gives an exact charge
  always_ff @(posedge clock_i) begin
    done_o <= 1'b0;
    if (arm_i) begin
      left <= win_i;
      cnt_o <= 32'h0;
    end else if (left != 32'h0) begin
      left <= left - 32'h1;
      cnt_o <= cnt_o + 32'(pwm_i);
      done_o <= (left == 32'h1);
    end
  end
endmodule // fpd_lpf_model

// File: tb/fpd_top_tb.sv
/*
  Bench for fpd_top: register traffic over AXI4-Lite and high-time checks on pwm_o.
  Assumes the select-6 divider is shortened to 2 clocks to keep runs short.
*/
`timescale 1ns/1ps
module fpd_top_tb;
  localparam int DIV = 2;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] win = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, arm = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pwm, m_done;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, m_cnt, rnd;
  logic [33:0] got;
  logic [33:0] expq[$];
  int          n_fail = 0, total_checks = 0, seed = 32'h4794;

  // Clock at 200 MHz
  always #2.5 clock_i = ~clock_i;

  fpd_top #(.P_DIV_TOP(DIV)) dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pwm_o(pwm)
  );

  fpd_lpf_model lpf_u (.clock_i(clock_i), .pwm_i(pwm), .arm_i(arm), .win_i(win), .done_o(m_done), .cnt_o(m_cnt));

  // Oldest note against each bus answer (response code on top) or finished measurement
  always @(posedge clock_i) begin
    if ((rvalid && rready) || (bvalid && bready) || m_done) begin
      got = m_done ? {2'b00, m_cnt} : (rvalid && rready) ? {rresp, rdata} : {bresp, 32'h0};
      total_checks++;
      if (expq.size() == 0 || got !== expq[0]) begin
        n_fail++;
        $display("wrong value at %0t: got %h expected %h", $time, got, expq[0]);
      end
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end

  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    expq.push_back({fpd_pkg::RESP_OKAY, 32'h0});
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back({fpd_pkg::RESP_OKAY, e});
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic meas(input logic [31:0] w, input logic [31:0] e);
    expq.push_back({2'b00, e});
    @(posedge clock_i);
    arm <= 1'b1;
    win <= w;
    @(posedge clock_i);
    arm <= 1'b0;
    do @(posedge clock_i); while (!m_done);
  endtask

  // High clocks over k base pulses; a full cycle adds one step per extra pulse
  function automatic logic [31:0] exp_hi(input logic cls, input logic inv, input logic [13:0] v, input int k);
    int np, d, f, a;
    np = cls ? 64 : 256;
    d = cls ? int'(v[13:6]) : int'(v[13:8]);
    f = cls ? int'(v[5:0]) : int'(v[7:0]);
    a = (d * k + ((k == np && d != 0) ? f : 0)) * DIV;
    return inv ? 32'(a) : 32'(k * (cls ? 256 : 64) * DIV - a);
  endfunction

  // New setting is taken at a pulse end, so settle for one long pulse first
  task automatic run(input logic cls, input logic inv, input logic [13:0] v, input int k);
    wr(fpd_pkg::OFF_CTRL, {30'h0, inv, cls});
    wr(fpd_pkg::OFF_VALUE, {18'h0, v});
    repeat (600) @(posedge clock_i);
    meas(32'(k * (cls ? 256 : 64) * DIV), exp_hi(cls, inv, v, k));
  endtask

  task automatic finish_test();
    // Notes that never got an answer count as mismatches
    n_fail += expq.size();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    meas(32'h10, 32'h10);
    rd(fpd_pkg::OFF_CTRL, 32'h0);
    rd(fpd_pkg::OFF_PRESC, 32'h0);
    rd(fpd_pkg::OFF_VALUE, 32'h0);
    wr(fpd_pkg::OFF_CTRL, 32'hffffffff);
    rd(fpd_pkg::OFF_CTRL, 32'h3);
    wr(fpd_pkg::OFF_VALUE, 32'hffffffff);
    rd(fpd_pkg::OFF_VALUE, 32'h3fff);
    wr(fpd_pkg::OFF_PRESC, 32'h6);
    rd(fpd_pkg::OFF_PRESC, 32'h6);
    run(1'b1, 1'b1, 14'h0040, 4);
    run(1'b1, 1'b0, 14'h0040, 4);
    run(1'b1, 1'b1, 14'h003f, 4);
    run(1'b1, 1'b0, 14'h003f, 4);
    run(1'b0, 1'b1, 14'h00ff, 4);
    run(1'b0, 1'b1, 14'h0100, 4);
    run(1'b0, 1'b0, 14'h3f00, 4);
    rnd = $random(seed);
    run(1'b1, 1'b1, (rnd[13:0] | 14'h2000) & 14'h3ffc, 64);
    run(1'b0, 1'b1, rnd[29:16] | 14'h2000, 256);
    // Let the checker take the last answer before the verdict
    repeat (2) @(posedge clock_i);
    finish_test();
  end

  // Watchdog sized a little above the expected run of about 81000 clocks
  initial begin
    repeat (95000) @(posedge clock_i);
    n_fail++;
    finish_test();
  end
endmodule // fpd_top_tb
